// File: rtl/aem_status_monitor.sv
// How it works
// - Fill level sits in operational bits 1-3.
// - Fill code n means n/8 < fill <= (n+1)/8.
// - Operational bit 5 follows heating criterion.
// - Operational bit 6 follows actual heating output.
// - Short averaging: ten seconds without value errors.
// - Long averaging: under half buffer filled errors.
// - Fault lasting over one minute sets static bit.
// - Stale data sets error bits, forces analog.
// - Error level select picks analog minimum or maximum.
// - On error, error telegram replaces normal telegram.
// - Nonzero restart timeout requests restart when starved.
// - Up to three implausible values in a row are discarded before buffering; the fourth is accepted.
// - Only accepted values are ever output.
// - Heating criterion: ten seconds failure, supply above threshold.
`include "aem_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module aem_status_monitor #(
  parameter int unsigned TICK_CYCLES = `AEM_TICK_CYCLES,
  parameter int unsigned AVG_MAX = 64,
  parameter int unsigned SUP_W = 12
) (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Raw measurements from acquisition
  input wire logic raw_valid,
  input wire logic [`AEM_VALUE_W-1:0] raw_value,
  input wire logic virtual_temperature_fault,
  // Settings
  input wire logic [7:0] averaging_time_setting,
  input wire logic error_level_select,
  input wire logic [7:0] restart_timeout_setting,
  input wire logic [SUP_W-1:0] supply_threshold_setting,
  input wire logic analog_enable,
  // Supply and heating
  input wire logic [SUP_W-1:0] supply_voltage,
  input wire logic heating_output,
  // Status bytes
  output aem_pkg::aem_op_status_t operational_status_byte,
  output aem_pkg::aem_err_status_t error_status_byte,
  // Outputs toward telegram and analog stages
  output aem_pkg::aem_sample_t sample_out,
  output logic [`AEM_VALUE_W-1:0] analog_out,
  output logic error_telegram_select,
  output logic restart_request
);
  import aem_pkg::*;

  localparam int unsigned TW = 32;

  // Number of ones among the newest av history slots
  function automatic logic [7:0] count_recent(input logic [AVG_MAX-1:0] hist, input logic [7:0] av);
    logic [7:0] cnt;
    cnt = 8'h00;
    for (int i = 0; i < AVG_MAX; i++) begin
      if ((i < int'(av)) && hist[i]) begin
        cnt = cnt + 8'h01;
      end
    end
    return cnt;
  endfunction

  // Code n for n/8 < cnt/av <= (n+1)/8, i.e. ceil(8*cnt/av)-1
  function automatic logic [2:0] fill_code(input logic [7:0] cnt, input logic [7:0] av);
    logic [11:0] num;
    logic [11:0] q;
    logic [7:0] den;
    den = (av == 8'h00) ? 8'h01 : av;
    num = {1'b0, cnt, 3'h0} + {4'h0, den} - 12'h001;
    q = num / {4'h0, den};
    if (cnt == 8'h00 || q == 12'h000) begin
      return 3'h0;
    end else if (q > 12'h008) begin
      return 3'h7;
    end else begin
      return 3'(q - 12'h001);
    end
  endfunction

  function automatic logic [7:0] sat_inc(input logic [7:0] v);
    return (v == 8'hFF) ? v : v + 8'h01;
  endfunction

  // One-second tick
  logic [TW-1:0] tick_cnt_reg, tick_cnt_next;
  logic tick;

  assign tick = (tick_cnt_reg == TW'(TICK_CYCLES - 1));

  always_comb begin
    tick_cnt_next = tick ? '0 : tick_cnt_reg + TW'(1);
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      tick_cnt_reg <= '0;
    end else begin
      tick_cnt_reg <= tick_cnt_next;
    end
  end

  // Plausibility check against the last accepted value
  logic [`AEM_VALUE_W-1:0] last_reg, last_next;
  logic have_hist_reg, have_hist_next;
  logic [1:0] reject_cnt_reg, reject_cnt_next;
  logic [`AEM_VALUE_W-1:0] diff;
  logic accept;

  assign diff = (raw_value > last_reg) ? raw_value - last_reg : last_reg - raw_value;
  // A run of rejects reseeds, so a genuine step change is not locked out forever
  assign accept = raw_valid && (!have_hist_reg || diff <= `AEM_JUMP_LIMIT ||
                                reject_cnt_reg == `AEM_REJECT_RESEED);

  always_comb begin
    last_next = last_reg;
    have_hist_next = have_hist_reg;
    reject_cnt_next = reject_cnt_reg;
    if (accept) begin
      last_next = raw_value;
      have_hist_next = 1'b1;
      reject_cnt_next = 2'h0;
    end else if (raw_valid && reject_cnt_reg != `AEM_REJECT_RESEED) begin
      reject_cnt_next = reject_cnt_reg + 2'h1;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      last_reg <= '0;
      have_hist_reg <= 1'b0;
      reject_cnt_reg <= 2'h0;
    end else begin
      last_reg <= last_next;
      have_hist_reg <= have_hist_next;
      reject_cnt_reg <= reject_cnt_next;
    end
  end

  // Averaging buffer occupancy, one slot per second
  logic [AVG_MAX-1:0] hist_reg, hist_next;
  logic got_reg, got_next;
  logic [7:0] no_val_secs_reg, no_val_secs_next;
  logic [7:0] recent_cnt;

  assign recent_cnt = count_recent(hist_reg, averaging_time_setting);

  always_comb begin
    hist_next = hist_reg;
    got_next = got_reg | accept;
    no_val_secs_next = no_val_secs_reg;
    if (tick) begin
      hist_next = {hist_reg[AVG_MAX-2:0], got_reg | accept};
      // A value arriving on the tick counts for the closing second
      got_next = 1'b0;
    end
    if (accept) begin
      no_val_secs_next = 8'h00;
    end else if (tick) begin
      no_val_secs_next = sat_inc(no_val_secs_reg);
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      hist_reg <= '0;
      got_reg <= 1'b0;
      no_val_secs_reg <= 8'h00;
    end else begin
      hist_reg <= hist_next;
      got_reg <= got_next;
      no_val_secs_reg <= no_val_secs_next;
    end
  end

  // Error evaluation on the tick
  logic general_reg, general_next;
  logic static_reg, static_next;
  logic [7:0] fault_secs_reg, fault_secs_next;
  logic general_now;
  logic fault_now;
  logic stale;

  assign stale = (no_val_secs_reg >= `AEM_STALE_LIMIT_S);

  always_comb begin
    if (averaging_time_setting < `AEM_SHORT_AVG_LIMIT_S) begin
      general_now = stale;
    end else begin
      general_now = ({recent_cnt, 1'b0} < {1'b0, averaging_time_setting});
    end
  end

  assign fault_now = general_now | stale | virtual_temperature_fault;

  always_comb begin
    general_next = general_reg;
    static_next = static_reg;
    fault_secs_next = fault_secs_reg;
    if (tick) begin
      general_next = general_now;
      fault_secs_next = fault_now ? sat_inc(fault_secs_reg) : 8'h00;
      static_next = fault_now && (fault_secs_reg >= `AEM_STATIC_LIMIT_S);
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      general_reg <= 1'b0;
      static_reg <= 1'b0;
      fault_secs_reg <= 8'h00;
    end else begin
      general_reg <= general_next;
      static_reg <= static_next;
      fault_secs_reg <= fault_secs_next;
    end
  end

  // Restart request, once per starvation episode
  logic restart_reg, restart_next;
  logic restart_done_reg, restart_done_next;

  always_comb begin
    restart_next = 1'b0;
    restart_done_next = restart_done_reg;
    if (accept) begin
      restart_done_next = 1'b0;
    end else if (restart_timeout_setting != 8'h00 && !restart_done_reg &&
                 no_val_secs_reg >= restart_timeout_setting) begin
      restart_next = 1'b1;
      restart_done_next = 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      restart_reg <= 1'b0;
      restart_done_reg <= 1'b0;
    end else begin
      restart_reg <= restart_next;
      restart_done_reg <= restart_done_next;
    end
  end

  // Status bytes, analog and telegram outputs
  aem_op_status_t op_reg, op_next;
  aem_err_status_t err_reg, err_next;
  aem_sample_t sample_reg, sample_next;
  logic [`AEM_VALUE_W-1:0] analog_reg, analog_next;
  logic [`AEM_VALUE_W-1:0] held_reg, held_next;
  logic telegram_reg, telegram_next;
  logic error_any;

  assign error_any = general_reg | static_reg;

  always_comb begin
    op_next = `AEM_OP_STATUS_RESET;
    op_next.fill_level = fill_code(recent_cnt, averaging_time_setting);
    op_next.heating_criterion = (no_val_secs_reg >= `AEM_HEAT_FAIL_S) &&
                                (supply_voltage > supply_threshold_setting);
    op_next.heating_on = heating_output;
    err_next = `AEM_ERR_STATUS_RESET;
    err_next.general_malfunction = general_reg;
    err_next.static_malfunction = static_reg;
  end

  always_comb begin
    held_next = accept ? raw_value : held_reg;
    sample_next.valid = accept;
    sample_next.value = accept ? raw_value : sample_reg.value;
    telegram_next = error_any;
    if (!analog_enable) begin
      // Disabled outputs are parked low and take no error level
      analog_next = `AEM_ANALOG_MIN;
    end else if (error_any) begin
      analog_next = error_level_select ? `AEM_ANALOG_MAX : `AEM_ANALOG_MIN;
    end else begin
      analog_next = held_next;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      op_reg <= `AEM_OP_STATUS_RESET;
      err_reg <= `AEM_ERR_STATUS_RESET;
      sample_reg <= '0;
      analog_reg <= `AEM_ANALOG_MIN;
      held_reg <= '0;
      telegram_reg <= 1'b0;
    end else begin
      op_reg <= op_next;
      err_reg <= err_next;
      sample_reg <= sample_next;
      analog_reg <= analog_next;
      held_reg <= held_next;
      telegram_reg <= telegram_next;
    end
  end

  assign operational_status_byte = op_reg;
  assign error_status_byte = err_reg;
  assign sample_out = sample_reg;
  assign analog_out = analog_reg;
  assign error_telegram_select = telegram_reg;
  assign restart_request = restart_reg;

endmodule

`default_nettype wire

// File: rtl/aem_defines.svh
`ifndef AEM_DEFINES_SVH
`define AEM_DEFINES_SVH

// Clock and measurement tick
`define AEM_CLK_PERIOD_NS 40
`define AEM_TICK_PERIOD_NS 1000000000
`define AEM_TICK_CYCLES (`AEM_TICK_PERIOD_NS / `AEM_CLK_PERIOD_NS)

// Value width and plausibility check
`define AEM_VALUE_W 16
`define AEM_JUMP_LIMIT 16'h0800
`define AEM_REJECT_RESEED 2'h3

// Time limits in seconds
`define AEM_SHORT_AVG_LIMIT_S 8'h0A
`define AEM_STALE_LIMIT_S 8'h0A
`define AEM_STATIC_LIMIT_S 8'h3C
`define AEM_HEAT_FAIL_S 8'h0A

// Analog error levels
`define AEM_ANALOG_MIN 16'h0000
`define AEM_ANALOG_MAX 16'hFFFF

// Reset values of the status bytes
`define AEM_OP_STATUS_RESET 8'h00
`define AEM_ERR_STATUS_RESET 8'h00

`endif

// File: rtl/aem_pkg.sv
`include "aem_defines.svh"

package aem_pkg;

  typedef struct packed {
    logic rsvd7;
    logic heating_on;
    logic heating_criterion;
    logic rsvd4;
    logic [2:0] fill_level;
    logic rsvd0;
  } aem_op_status_t;

  typedef struct packed {
    logic [5:0] rsvd;
    logic static_malfunction;
    logic general_malfunction;
  } aem_err_status_t;

  typedef struct packed {
    logic valid;
    logic [`AEM_VALUE_W-1:0] value;
  } aem_sample_t;

endpackage

// File: test/aem_status_monitor_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module aem_status_monitor_assertions
  import aem_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = 20
) (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Inputs watched
  input wire logic raw_valid,
  input wire logic [15:0] raw_value,
  input wire logic [7:0] averaging_time_setting,
  input wire logic error_level_select,
  input wire logic [7:0] restart_timeout_setting,
  input wire logic [11:0] supply_threshold_setting,
  input wire logic analog_enable,
  input wire logic [11:0] supply_voltage,
  input wire logic heating_output,
  // Outputs watched
  input wire aem_pkg::aem_op_status_t operational_status_byte,
  input wire aem_pkg::aem_err_status_t error_status_byte,
  input wire aem_pkg::aem_sample_t sample_out,
  input wire logic [15:0] analog_out,
  input wire logic error_telegram_select,
  input wire logic restart_request
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  // Cycles since the last accepted value, saturating
  logic [31:0] quiet;
  always_ff @(posedge clock) begin
    quiet <= (sys_rst || sample_out.valid) ? 32'h0 : quiet + {31'h0, quiet != 32'hFFFFFFFF};
  end
  sequence s_err_held;
    (analog_enable && error_telegram_select && $stable(error_level_select)) [*2];
  endsequence
  property p_rsvd;
    {operational_status_byte.rsvd7, operational_status_byte.rsvd4, operational_status_byte.rsvd0,
     error_status_byte.rsvd} == 9'h000;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved status bit set");
  property p_accept;
    sample_out.valid |-> $past(raw_valid) && sample_out.value == $past(raw_value);
  endproperty
  a_accept: assert property (p_accept) else $error("output value not from input");
  property p_heat_on;
    !$past(sys_rst) && !$past(sys_rst, 2) |-> operational_status_byte.heating_on == $past(heating_output);
  endproperty
  a_heat_on: assert property (p_heat_on) else $error("heating on bit wrong");
  property p_tel;
    error_telegram_select == (error_status_byte.general_malfunction | error_status_byte.static_malfunction);
  endproperty
  a_tel: assert property (p_tel) else $error("telegram select disagrees with flags");
  property p_analog_err;
    s_err_held |-> analog_out == (error_level_select ? 16'hFFFF : 16'h0000);
  endproperty
  a_analog_err: assert property (p_analog_err) else $error("analog error level wrong");
  property p_analog_off;
    (!analog_enable) [*2] |-> analog_out == 16'h0000;
  endproperty
  a_analog_off: assert property (p_analog_off) else $error("disabled analog not zero");
  property p_restart;
    restart_request |-> (restart_timeout_setting != 8'h00) ##1 !restart_request;
  endproperty
  a_restart: assert property (p_restart) else $error("restart pulse wrong");
  property p_general;
    $rose(error_status_byte.general_malfunction) && averaging_time_setting < 8'h0A |-> quiet >= 9 * TICK_CYCLES;
  endproperty
  a_general: assert property (p_general) else $error("general flag too early");
  property p_crit;
    $rose(operational_status_byte.heating_criterion) |->
      quiet >= 9 * TICK_CYCLES && supply_voltage > supply_threshold_setting;
  endproperty
  a_crit: assert property (p_crit) else $error("heating criterion too early");
endmodule
bind aem_status_monitor aem_status_monitor_assertions #(.TICK_CYCLES(TICK_CYCLES)) aem_status_monitor_assertions_inst (.*);
`default_nettype wire

// File: test/aem_host_logger.sv
`timescale 1ns/1ps
`default_nettype none
module aem_host_logger
  import aem_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Telegram stream
  input wire aem_pkg::aem_sample_t sample_out,
  input wire logic error_telegram_select,
  input wire logic restart_request,
  // Tallies
  output var int data_seen,
  output var int alarm_seen,
  output var int restarts_seen
);
  logic tel_q;
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      tel_q <= 1'b0;
      data_seen <= 0;
      alarm_seen <= 0;
      restarts_seen <= 0;
    end else begin
      tel_q <= error_telegram_select;
      // A data telegram only leaves while no error telegram replaces it
      data_seen <= data_seen + int'(sample_out.valid && !error_telegram_select);
      alarm_seen <= alarm_seen + int'(error_telegram_select && !tel_q);
      restarts_seen <= restarts_seen + int'(restart_request);
    end
  end
endmodule
`default_nettype wire

// File: test/aem_status_monitor_bench.sv
`timescale 1ns/1ps
`default_nettype none
module aem_status_monitor_bench;
  import aem_pkg::*;
  localparam int TK = 20;
  logic clock = 0, sys_rst = 1, raw_valid = 0, virtual_temperature_fault = 0, heating_output = 0;
  logic error_level_select = 0, analog_enable = 1;
  logic [15:0] raw_value = 16'h0000, analog_out, last_v;
  logic [7:0] averaging_time_setting = 8'h02, restart_timeout_setting = 8'h05;
  logic [11:0] supply_threshold_setting = 12'h100, supply_voltage = 12'h200;
  aem_op_status_t operational_status_byte;
  aem_err_status_t error_status_byte;
  aem_sample_t sample_out;
  logic error_telegram_select, restart_request;
  int err_count = 0, samples_checked = 0, data_seen, alarm_seen, restarts_seen;
  // Top bit: value expected to pass the plausibility check
  logic [16:0] rows [8] = '{17'h1_0100, 17'h1_0900, 17'h0_1200, 17'h0_1200, 17'h0_1200, 17'h1_1200,
                            17'h1_0A00, 17'h0_0100};
  aem_status_monitor #(.TICK_CYCLES(TK)) aem_status_monitor_inst (.*);
  aem_host_logger aem_host_logger_inst (.*);
  initial begin
    forever #20 clock = ~clock;
  end
  task automatic tally_and_finish;
    if (err_count == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic feed(input logic [15:0] v);
    raw_value = v;
    raw_valid = 1;
    cyc(1);
    raw_valid = 0;
  endtask
  task automatic wait_err(input int b, input int lim);
    int i;
    for (i = 0; i < lim && error_status_byte[b] !== 1'b1; i++)
      cyc(1);
    if (error_status_byte[b] !== 1'b1) begin
      chk(error_status_byte[b], 1'b1);
      tally_and_finish();
    end
  endtask
  initial begin
    cyc(4);
    chk({operational_status_byte, error_status_byte, analog_out}, 32'h0);
    cyc(1);
    sys_rst = 0;
    foreach (rows[i]) begin
      feed(rows[i][15:0]);
      if (rows[i][16])
        last_v = rows[i][15:0];
      chk(sample_out.valid, rows[i][16]);
      chk(sample_out.value, last_v);
      chk(analog_out, last_v);
      cyc(1);
    end
    // Second reset gives the fill ramp a clean history and second phase
    sys_rst = 1;
    averaging_time_setting = 8'h08;
    cyc(2);
    sys_rst = 0;
    cyc(4);
    for (int i = 1; i <= 8; i++) begin
      feed(16'h0100 + 16'(i));
      cyc(19);
      chk(operational_status_byte.fill_level, i - 1);
    end
    chk(data_seen, 8);
    cyc(8 * TK);
    chk(error_status_byte.general_malfunction, 0);
    wait_err(0, 3 * TK);
    cyc(2);
    chk(operational_status_byte.heating_criterion, 1);
    chk({error_telegram_select, analog_out}, 17'h1_0000);
    supply_threshold_setting = 12'h300;
    heating_output = 1;
    cyc(2);
    chk(operational_status_byte.heating_criterion, 0);
    chk(operational_status_byte.heating_on, 1);
    supply_threshold_setting = 12'h100;
    heating_output = 0;
    error_level_select = 1;
    cyc(3);
    chk(analog_out, 16'hFFFF);
    analog_enable = 0;
    cyc(3);
    chk(analog_out, 16'h0000);
    analog_enable = 1;
    error_level_select = 0;
    cyc(58 * TK);
    chk(error_status_byte.static_malfunction, 0);
    wait_err(1, 3 * TK);
    chk({alarm_seen[15:0], restarts_seen[15:0]}, {16'd1, 16'd1});
    for (int i = 0; i < 12; i++) begin
      feed(16'h0200);
      cyc(19);
    end
    chk({error_status_byte, error_telegram_select, analog_out}, 25'h0_0200);
    chk(operational_status_byte.heating_criterion, 0);
    // Twelve good seconds: exactly half of 24 passes, short of half of 26 fails
    averaging_time_setting = 8'h18;
    cyc(21);
    chk(error_status_byte.general_malfunction, 0);
    averaging_time_setting = 8'h1A;
    cyc(21);
    chk(error_status_byte.general_malfunction, 1);
    // Values keep arriving, so only the temperature fault can raise the static flag
    averaging_time_setting = 8'h02;
    virtual_temperature_fault = 1;
    for (int i = 0; i < 58; i++) begin
      feed(16'h0200);
      cyc(19);
    end
    chk(error_status_byte.static_malfunction, 0);
    wait_err(1, 3 * TK);
    chk(error_status_byte.general_malfunction, 0);
    tally_and_finish();
  end
endmodule
`default_nettype wire
